// ===== design/sjtap_consts.svh
// Constants for the SRAM test access port.
`ifndef SJTAP_CONSTS_SVH
`define SJTAP_CONSTS_SVH
`define SJTAP_IR_LEN 3
`define SJTAP_BSR_LEN 109
`define SJTAP_ID_LEN 32
`define SJTAP_IR_EXTEST 3'h0
`define SJTAP_IR_IDCODE 3'h1
`define SJTAP_IR_SAMPZ 3'h2
`define SJTAP_IR_SAMPLE 3'h4
`define SJTAP_IR_BYPASS 3'h7
`define SJTAP_IR_CAPT 3'h1
`define SJTAP_TRI_BIT 108
`define SJTAP_ID_PRES 1'h1
`define SJTAP_BYP_CAPT 1'h0
`define SJTAP_CLK_MHZ 100
`define SJTAP_LOCK_US 20
`define SJTAP_LOCK_CYC (`SJTAP_LOCK_US * `SJTAP_CLK_MHZ)
`define SJTAP_CNT_W 12
`endif

// ===== design/sjtap_pkg.sv
// Types shared by the SRAM test access port.
package sjtap_pkg;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
	} sjtap_state_e;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic pll_en;
		logic ref_ok;
	} sjtap_pins_s;
endpackage

// ===== design/sjtap_tap.sv
// Test access port with boundary scan and PLL lock tracking for the SRAM.
`timescale 1ns/1ps
`default_nettype none
`include "sjtap_consts.svh"

// Operation
// RQ1: Provide 3-bit instruction, 1-bit bypass, 32-bit ID, 109-bit boundary paths.
// RQ2: Code 000 captures the pin ring into the boundary register.
// RQ3: Code 001 captures the fixed ID and routes it to TDO.
// RQ4: Code 010 captures pins, selects boundary register, tristates memory outputs.
// RQ5: Controller never loads reserved codes 011, 101 or 110.
// RQ6: Code 100 captures the ring, selects boundary register, memory unaffected.
// RQ7: Code 111 places the single bypass bit between TDI and TDO.
// RQ8: ID bits 31 to 29 hold the version field.
// RQ9: ID bits 28 to 12 hold the part-type field.
// RQ10: ID bits 11 to 1 hold the manufacturer field.
// RQ11: ID bit 0 always reads one.
// RQ12: TDO changes only after a falling TCK edge.
// RQ13: TMS and TDI are sampled on the rising TCK edge.
// RQ14: System holds PLL enable and clock stable 20 us for lock.
// RQ15: After an unstable clock, system gives 20 us stable clock.
// RQ16: PLL lock follows the rising-edge reference clock.
// RQ17: Cell 108 gates outputs under external test, presets to one.
// RQ18: ID instruction becomes current at reset and in Test-Logic-Reset.
// RQ19: Boundary bit 0 leaves first, the top bit sits by TDI.
// RQ20: High-impedance sampling holds outputs off until the next Update-IR.
// RQ21: Bypass captures zero in Capture-DR.
// RQ22: Instructions change only at Update-IR, preload only at Update-DR.
module sjtap_tap
	import sjtap_pkg::*;
#(
	parameter int BSR_LEN = `SJTAP_BSR_LEN,
	parameter logic [2:0] ID_VERSION = 3'h5, // Arbitrary value.
	parameter logic [16:0] ID_PART = 17'h0a5c3, // Arbitrary value.
	parameter logic [10:0] ID_MAKER = 11'h2b6 // Arbitrary value.
) (
	input wire logic clk, // System clock, 100 MHz.
	input wire logic rst_n, // Power-up reset, active low.
	input wire sjtap_pins_s pins, // Raw TAP and PLL control pins.
	input wire logic [BSR_LEN-2:0] ring_in, // Pin ring levels.
	output logic tdo_q, // Test data out.
	output logic tdo_oe_q, // High while TDO is driven.
	output logic [BSR_LEN-2:0] preload_q, // Preloaded cell values.
	output logic extest_q, // External test drives the pins.
	output logic out_drive_q, // Memory output drivers enabled.
	output logic pll_locked_q // PLL considered locked.
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and TCK edge detection.

	sjtap_pins_s pins_s1_q;
	sjtap_pins_s pins_s2_q;
	logic tck_prev_q;
	logic [BSR_LEN-2:0] ring_s1_q;
	logic [BSR_LEN-2:0] ring_s2_q;
	logic tck_rise;
	logic tck_fall;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_s1_q <= '0;
			pins_s2_q <= '0;
			tck_prev_q <= 1'h0;
		end else begin
			pins_s1_q <= pins;
			pins_s2_q <= pins_s1_q;
			tck_prev_q <= pins_s2_q.tck;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ring_s1_q <= '0;
			ring_s2_q <= '0;
		end else begin
			ring_s1_q <= ring_in;
			ring_s2_q <= ring_s1_q;
		end
	end

	assign tck_rise = pins_s2_q.tck && !tck_prev_q;
	assign tck_fall = !pins_s2_q.tck && tck_prev_q;

	////////////////////////////////////////////////////////////////////////
	// TAP state machine.

	sjtap_state_e state_q;
	sjtap_state_e state_d;

	always_comb begin
		state_d = state_q;
		case (state_q)
			TLR: state_d = pins_s2_q.tms ? TLR : RTI;
			RTI: state_d = pins_s2_q.tms ? SEL_DR : RTI;
			SEL_DR: state_d = pins_s2_q.tms ? SEL_IR : CAP_DR;
			CAP_DR: state_d = pins_s2_q.tms ? EX1_DR : SH_DR;
			SH_DR: state_d = pins_s2_q.tms ? EX1_DR : SH_DR;
			EX1_DR: state_d = pins_s2_q.tms ? UP_DR : PA_DR;
			PA_DR: state_d = pins_s2_q.tms ? EX2_DR : PA_DR;
			EX2_DR: state_d = pins_s2_q.tms ? UP_DR : SH_DR;
			UP_DR: state_d = pins_s2_q.tms ? SEL_DR : RTI;
			SEL_IR: state_d = pins_s2_q.tms ? TLR : CAP_IR;
			CAP_IR: state_d = pins_s2_q.tms ? EX1_IR : SH_IR;
			SH_IR: state_d = pins_s2_q.tms ? EX1_IR : SH_IR;
			EX1_IR: state_d = pins_s2_q.tms ? UP_IR : PA_IR;
			PA_IR: state_d = pins_s2_q.tms ? EX2_IR : PA_IR;
			EX2_IR: state_d = pins_s2_q.tms ? UP_IR : SH_IR;
			UP_IR: state_d = pins_s2_q.tms ? SEL_DR : RTI;
			default: state_d = TLR;
		endcase
	end

	// RQ13: advance on TCK rise.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= TLR;
		end else if (tck_rise) begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction register.

	// RQ1: scan path widths.
	logic [`SJTAP_IR_LEN-1:0] ir_sr_q;
	logic [`SJTAP_IR_LEN-1:0] cur_ir_q;
	logic bsr_sel;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_sr_q <= `SJTAP_IR_CAPT;
		end else if (tck_rise && state_q == CAP_IR) begin
			ir_sr_q <= `SJTAP_IR_CAPT;
		end else if (tck_rise && state_q == SH_IR) begin
			ir_sr_q <= {pins_s2_q.tdi, ir_sr_q[`SJTAP_IR_LEN-1:1]};
		end
	end

	// RQ18: reset loads ID instruction.
	// RQ22: update only at Update-IR.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur_ir_q <= `SJTAP_IR_IDCODE;
		end else if (state_q == TLR) begin
			cur_ir_q <= `SJTAP_IR_IDCODE;
		end else if (tck_fall && state_q == UP_IR) begin
			cur_ir_q <= ir_sr_q;
		end
	end

	// RQ2: boundary-path instructions.
	assign bsr_sel = (cur_ir_q == `SJTAP_IR_EXTEST) || (cur_ir_q == `SJTAP_IR_SAMPZ) ||
		(cur_ir_q == `SJTAP_IR_SAMPLE);

	////////////////////////////////////////////////////////////////////////
	// Data registers: bypass, identification, boundary scan.

	logic byp_q;
	logic [`SJTAP_ID_LEN-1:0] id_sr_q;
	logic [BSR_LEN-1:0] bsr_q;
	logic tri_cell_q;
	logic [`SJTAP_ID_LEN-1:0] id_value;

	// RQ8: version field, RQ9: part field, RQ10: maker field, RQ11: presence bit.
	assign id_value = {ID_VERSION, ID_PART, ID_MAKER, `SJTAP_ID_PRES};

	// RQ21: bypass captures zero.
	// RQ7: single-bit bypass shift.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byp_q <= `SJTAP_BYP_CAPT;
		end else if (tck_rise && state_q == CAP_DR) begin
			byp_q <= `SJTAP_BYP_CAPT;
		end else if (tck_rise && state_q == SH_DR) begin
			byp_q <= pins_s2_q.tdi;
		end
	end

	// RQ3: capture fixed code under the ID instruction.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			id_sr_q <= '0;
		end else if (tck_rise && state_q == CAP_DR && cur_ir_q == `SJTAP_IR_IDCODE) begin
			id_sr_q <= id_value;
		end else if (tck_rise && state_q == SH_DR && cur_ir_q == `SJTAP_IR_IDCODE) begin
			id_sr_q <= {pins_s2_q.tdi, id_sr_q[`SJTAP_ID_LEN-1:1]};
		end
	end

	// RQ6: capture pin ring plus tristate cell.
	// RQ19: shift toward bit 0, TDI enters the top.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bsr_q <= '0;
		end else if (tck_rise && state_q == CAP_DR && bsr_sel) begin
			bsr_q <= {tri_cell_q, ring_s2_q};
		end else if (tck_rise && state_q == SH_DR && bsr_sel) begin
			bsr_q <= {pins_s2_q.tdi, bsr_q[BSR_LEN-1:1]};
		end
	end

	// RQ17: tristate cell presets to one.
	// RQ22: preload latches only at Update-DR.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tri_cell_q <= 1'h1;
			preload_q <= '0;
		end else if (state_q == TLR) begin
			tri_cell_q <= 1'h1;
		end else if (tck_fall && state_q == UP_DR && bsr_sel) begin
			tri_cell_q <= bsr_q[`SJTAP_TRI_BIT];
			preload_q <= bsr_q[BSR_LEN-2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output driver control.

	// RQ4: sampling with high impedance forces outputs off.
	// RQ20: held until the instruction changes.
	// RQ17: external test follows the tristate cell.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_drive_q <= 1'h1;
			extest_q <= 1'h0;
		end else begin
			extest_q <= (cur_ir_q == `SJTAP_IR_EXTEST);
			if (cur_ir_q == `SJTAP_IR_SAMPZ) begin
				out_drive_q <= 1'h0;
			end else if (cur_ir_q == `SJTAP_IR_EXTEST) begin
				out_drive_q <= tri_cell_q;
			end else begin
				out_drive_q <= 1'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// TDO launch.

	logic dr_bit;

	always_comb begin
		dr_bit = byp_q;
		if (cur_ir_q == `SJTAP_IR_IDCODE) begin
			dr_bit = id_sr_q[0];
		end else if (bsr_sel) begin
			dr_bit = bsr_q[0];
		end
	end

	// RQ12: launch on the falling TCK edge.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tdo_q <= 1'h0;
			tdo_oe_q <= 1'h0;
		end else if (tck_fall) begin
			tdo_q <= (state_q == SH_IR) ? ir_sr_q[0] : dr_bit;
			tdo_oe_q <= (state_q == SH_IR) || (state_q == SH_DR);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// PLL lock tracking.

	logic [`SJTAP_CNT_W-1:0] lock_cnt_q;

	// RQ16: count system clock cycles while enabled and the reference is good.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lock_cnt_q <= '0;
			pll_locked_q <= 1'h0;
		end else if (!pins_s2_q.pll_en || !pins_s2_q.ref_ok) begin
			lock_cnt_q <= '0;
			pll_locked_q <= 1'h0;
		end else if (lock_cnt_q == `SJTAP_CNT_W'(`SJTAP_LOCK_CYC - 1)) begin
			pll_locked_q <= 1'h1;
		end else begin
			lock_cnt_q <= lock_cnt_q + `SJTAP_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_tdo_fall_only: assert property ($changed(tdo_q) |-> $past(tck_fall)) // RQ12
		else $error("TDO changed without a falling TCK edge");
	chk_state_on_rise: assert property ($changed(state_q) |-> $past(tck_rise)) // RQ13
		else $error("TAP state moved without a rising TCK edge");
	chk_tlr_idcode: assert property (state_q == TLR |=> cur_ir_q == `SJTAP_IR_IDCODE) // RQ18
		else $error("ID instruction not current in Test-Logic-Reset");
	chk_ir_update_only: assert property ($changed(cur_ir_q) |->
		$past(state_q == TLR || (tck_fall && state_q == UP_IR))) // RQ22
		else $error("Instruction changed outside Update-IR");
	chk_bypass_zero: assert property (tck_rise && state_q == CAP_DR |=> byp_q == 1'h0) // RQ21
		else $error("Bypass did not capture zero");
	chk_id_capture: assert property (tck_rise && state_q == CAP_DR && cur_ir_q == `SJTAP_IR_IDCODE
		|=> id_sr_q == id_value && id_sr_q[0]) // RQ11
		else $error("ID capture wrong");
	chk_samplez_hiz: assert property (cur_ir_q == `SJTAP_IR_SAMPZ |=> !out_drive_q) // RQ4
		else $error("Outputs driven under high-impedance sampling");
	chk_extest_cell: assert property (cur_ir_q == `SJTAP_IR_EXTEST |=> out_drive_q == $past(tri_cell_q)) // RQ17
		else $error("Output enable does not follow the tristate cell");
	chk_tlr_cell_one: assert property (state_q == TLR |=> tri_cell_q) // RQ17
		else $error("Tristate cell not preset in Test-Logic-Reset");
	chk_pll_drop: assert property (!pins_s2_q.pll_en |=> !pll_locked_q && lock_cnt_q == '0) // RQ16
		else $error("PLL lock held with enable low");

	cov_ir_update: cover property (tck_fall && state_q == UP_IR);
	cov_extest_hiz: cover property (extest_q && !out_drive_q);
	cov_id_shift: cover property (tck_rise && state_q == SH_DR && cur_ir_q == `SJTAP_IR_IDCODE);
	cov_pll_lock: cover property ($rose(pll_locked_q));

endmodule
`default_nettype wire

// ===== tb/sjtap_ctl_model.sv
// Behavioural boundary-scan controller that drives the link pins of the test port.
`timescale 1ns/1ps
`default_nettype none

module sjtap_ctl_model (
	input wire logic clk, // System clock that paces the link clock.
	input wire logic tdo, // Test data from the device.
	output var logic tck, // Link clock, still between ticks.
	output var logic tms, // Mode select.
	output var logic tdi // Test data in, pulled high when idle.
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// change at low, hold through rise.
	task automatic tick(input logic m, input logic d, output logic q);
		@(negedge clk);
		tms = m;
		tdi = d;
		repeat (3) @(negedge clk);
		tck = 1'b1;
		repeat (2) @(negedge clk);
		q = tdo;
		repeat (2) @(negedge clk);
		tck = 1'b0;
	endtask

	task automatic tlr();
		logic q;
		repeat (5) tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
	endtask

	task automatic shift(input int n, input logic [108:0] din, output logic [108:0] dout);
		logic q;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], dout[i]);
		end
		tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
	endtask

	task automatic load_ir(input logic [2:0] code, output logic [2:0] cap);
		logic q;
		logic [108:0] o;
		tick(1'b1, 1'b1, q);
		tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tick(1'b0, 1'b1, q);
		shift(3, {106'h0, code}, o);
		cap = o[2:0];
	endtask

	task automatic scan_dr(input int n, input logic [108:0] din, output logic [108:0] dout);
		logic q;
		tick(1'b1, 1'b1, q);
		tick(1'b0, 1'b1, q);
		tick(1'b0, 1'b1, q);
		shift(n, din, dout);
	endtask
endmodule

`default_nettype wire

// ===== tb/sjtap_tap_tb.sv
// Self-checking testbench of the SRAM test access port.
`timescale 1ns/1ps
`default_nettype none
`include "sjtap_consts.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end

module sjtap_tap_tb
	import sjtap_pkg::*;
;
	logic clk, rst_n, tck, tms, tdi, pll_en, ref_ok;
	logic tdo_q, tdo_oe_q, extest_q, out_drive_q, pll_locked_q;
	logic [107:0] ring_in, preload_q;
	sjtap_pins_s pins;
	int fails, cmp_count, cyc;
	localparam logic [107:0] RA = {9{12'ha53}};
	localparam logic [107:0] RB = {9{12'h5c1}};
	localparam logic [107:0] PRE = {9{12'h3c6}};

	assign pins = {tck, tms, tdi, pll_en, ref_ok};

	// Identity values are arbitrary.
	sjtap_tap #(.ID_VERSION(3'h3), .ID_PART(17'h01234), .ID_MAKER(11'h155)) u_dut (
		.clk(clk), .rst_n(rst_n), .pins(pins), .ring_in(ring_in), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q),
		.preload_q(preload_q), .extest_q(extest_q), .out_drive_q(out_drive_q), .pll_locked_q(pll_locked_q));

	// A released TDO reads as its pull-up level.
	sjtap_ctl_model u_ctl (.clk(clk), .tdo(tdo_oe_q ? tdo_q : 1'b1), .tck(tck), .tms(tms), .tdi(tdi));

	initial clk = 1'b0;
	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			fails++;
			$display("[FAIL] %0t timeout", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic ir(input logic [2:0] code);
		logic [2:0] c;
		u_ctl.load_ir(code, c);
		`CHK(c, `SJTAP_IR_CAPT)
	endtask

	task automatic t_id();
		logic [108:0] o;
		for (int k = 0; k < 2; k++) begin
			u_ctl.scan_dr(32, {109{1'b1}}, o);
			`CHK(o[31:29], 3'h3)
			`CHK(o[28:12], 17'h01234)
			`CHK(o[11:1], 11'h155)
			`CHK(o[0], `SJTAP_ID_PRES)
		end
		`CHK(out_drive_q, 1'b1)
		$display("test id done");
	endtask

	task automatic t_byp();
		logic [108:0] o;
		ir(`SJTAP_IR_BYPASS);
		u_ctl.scan_dr(4, 109'hb, o);
		`CHK(o[3:1], 3'h3)
		`CHK(o[0], `SJTAP_BYP_CAPT)
		`CHK(tdo_oe_q, 1'b0)
		$display("test bypass done");
	endtask

	task automatic t_sample();
		logic [108:0] o;
		ir(`SJTAP_IR_SAMPLE);
		`CHK(preload_q, 108'h0)
		u_ctl.scan_dr(109, {1'b0, PRE}, o);
		`CHK(o[107:0], RA)
		`CHK(o[108], 1'b1)
		`CHK(preload_q, PRE)
		`CHK(out_drive_q, 1'b1)
		$display("test sample done");
	endtask

	task automatic t_extest();
		logic [108:0] o;
		@(negedge clk);
		ring_in = RB;
		ir(`SJTAP_IR_EXTEST);
		`CHK(out_drive_q, 1'b0)
		u_ctl.scan_dr(109, {1'b0, PRE}, o);
		`CHK(o[107:0], RB)
		u_ctl.tlr();
		`CHK(extest_q, 1'b0)
		ir(`SJTAP_IR_EXTEST);
		`CHK(extest_q, 1'b1)
		`CHK(out_drive_q, 1'b1)
		$display("test extest done");
	endtask

	task automatic t_sampz();
		logic [108:0] o;
		ir(`SJTAP_IR_SAMPZ);
		`CHK(out_drive_q, 1'b0)
		u_ctl.scan_dr(109, {109{1'b0}}, o);
		`CHK(o[107:0], RB)
		`CHK(out_drive_q, 1'b0)
		ir(`SJTAP_IR_BYPASS);
		`CHK(out_drive_q, 1'b1)
		$display("test high-z sample done");
	endtask

	task automatic t_pll();
		@(negedge clk);
		pll_en = 1'b1;
		ref_ok = 1'b1;
		repeat (1990) @(negedge clk);
		`CHK(pll_locked_q, 1'b0)
		repeat (20) @(negedge clk);
		`CHK(pll_locked_q, 1'b1)
		ref_ok = 1'b0;
		repeat (5) @(negedge clk);
		`CHK(pll_locked_q, 1'b0)
		ref_ok = 1'b1;
		repeat (2010) @(negedge clk);
		`CHK(pll_locked_q, 1'b1)
		$display("test pll done");
	endtask

	initial begin
		rst_n = 1'b0;
		pll_en = 1'b0;
		ref_ok = 1'b0;
		ring_in = RA;
		fails = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		u_ctl.tlr();
		t_id();
		t_byp();
		t_sample();
		t_extest();
		t_sampz();
		t_pll();
		report_and_stop();
	end
endmodule

`default_nettype wire
